//--- fcr_pkg.sv
// Package of constants and types for the fault capture recorder control
package fcr_pkg;
    // ------------------------------------------------------------
    // Timing, limits and reset values
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int DIG_PERIOD_US = 5000;
    localparam int DIG_PERIOD_CYC = (CLK_HZ / 1000) * DIG_PERIOD_US / 1000;
    localparam int PRE_MIN_DS = 2;
    localparam int PRE_MAX_DS = 150;
    localparam logic [7:0] PRE_RST_DS = 8'h02;
    localparam int MAX_AN_CH = 8;
    localparam int MAX_DIG_CH = 95;
    localparam int MAX_PUSHED = 6;
    localparam int MAX_CAPS = 100;
    localparam int SAMPLE_BYTES = 4;
    localparam logic [31:0] STORE_BYTES = 32'h0400_0000;
    localparam logic [1:0] SR_RST = 2'h0;
    localparam logic [15:0] LEN_RST_DS = 16'h000A;
    // ------------------------------------------------------------
    // Register offsets (byte address, word index = address / 4)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PRE = 8'h04;
    localparam logic [7:0] REG_LEN = 8'h08;
    localparam logic [7:0] REG_ANSEL = 8'h0C;
    localparam logic [7:0] REG_DIG0 = 8'h10;
    localparam logic [7:0] REG_DIG1 = 8'h14;
    localparam logic [7:0] REG_DIG2 = 8'h18;
    localparam logic [7:0] REG_CMD = 8'h1C;
    localparam logic [7:0] REG_STAT = 8'h20;
    localparam logic [7:0] REG_TOTAL = 8'h24;
    localparam logic [7:0] REG_EVT = 8'h28;
    localparam logic [7:0] REG_FREE = 8'h2C;
    // CTRL field positions
    localparam int CTRL_SR_LO = 0;
    localparam int CTRL_KEEP = 2;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_TRG_LO = 8;
    localparam int CTRL_FN60 = 16;
    // CMD bits
    localparam int CMD_TRIG = 0;
    localparam int CMD_CLR_ALL = 1;
    localparam int CMD_CLR_OLD = 2;
    localparam int CMD_CLR_NEW = 3;
    localparam int CMD_LOAD = 4;
    localparam int CMD_POP = 5;
    // Event codes
    typedef enum logic [3:0] {
        FCR_EV_TRIG_ON = 4'h0, FCR_EV_TRIG_OFF = 4'h1, FCR_EV_MEM_CLR = 4'h2,
        FCR_EV_OLD_CLR = 4'h3, FCR_EV_FULL_ON = 4'h4, FCR_EV_FULL_OFF = 4'h5,
        FCR_EV_REC_ON = 4'h6, FCR_EV_REC_OFF = 4'h7, FCR_EV_STO_ON = 4'h8,
        FCR_EV_STO_OFF = 4'h9, FCR_EV_NEW_CLR = 4'hA
    } fcr_ev_t;
    typedef enum logic [1:0] {
        FCR_IDLE = 2'b00, FCR_REC = 2'b01, FCR_STORE = 2'b10
    } fcr_st_t;
    typedef struct packed {
        logic valid;
        fcr_ev_t code;
        logic [31:0] stamp;
    } fcr_event_t;
endpackage

//--- fcr_len_calc.sv
// Sequential divider computing recording capacity in deciseconds
`timescale 1ns/100ps
`default_nettype none
module fcr_len_calc (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request
    input wire logic start,
    input wire logic [31:0] samples,
    input wire logic [31:0] rate,
    // Result
    output logic busy,
    output logic [31:0] quot
);
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [31:0] rem;
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] quot;
    } fcr_div_t;
    fcr_div_t s_q, s_d;
    logic [32:0] trial;

    // Restoring division, one bit a cycle; keeps area small at the cost of 32 cycles
    always_comb begin
        s_d = s_q;
        trial = {s_q.rem, s_q.num[31]} - {1'b0, s_q.den};
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 6'h20;
            s_d.rem = 32'h0;
            s_d.num = samples;
            s_d.den = rate;
        end else if (s_q.busy) begin
            s_d.num = {s_q.num[30:0], ~trial[32]};
            s_d.rem = trial[32] ? {s_q.rem[30:0], s_q.num[31]} : trial[31:0];
            s_d.cnt = s_q.cnt - 6'h01;
            if (s_q.cnt == 6'h01) begin
                s_d.busy = 1'b0;
                s_d.quot = (s_q.den == 32'h0) ? 32'h0 : {s_q.num[30:0], ~trial[32]};
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign busy = s_q.busy;
    assign quot = s_q.quot;
endmodule // fcr_len_calc
`default_nettype wire

//--- fcr_ctrl.sv
// Fault capture recorder control: settings, capture sequencing and events
//
// Operation
// - Digital channels sampled every 5 ms fixed
// - Pre-trigger time settable 0.2 to 15 s
// - Up to 8 analog channels selectable
// - Up to 95 digital channels selectable
// - Auto-transfer option pushes captures to client
// - At most six pushed captures held
// - Pushed capture no longer manually retrievable
// - Not ready when maximum length is zero
// - Samples are 4-byte words, 64 MB store
// - Timestamp word added per analog sample instant
// - Total length recomputed after settings load
// - Status-change and clear events raised
// - Events always logged, never masked; a clear command's event displaces a sequencer event in the same cycle
// - Every event carries a timestamp
// - Analog rate 64, 32, 16 or 8 s/c
// - Full memory overwrites oldest or refuses
// - Manual trigger returns to idle itself
// - At most one hundred captures stored
`timescale 1ns/100ps
`default_nettype none
module fcr_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Trigger sources and time base
    input wire logic [7:0] trig_in,
    input wire logic [31:0] time_now,
    // Sampling strobes
    output logic dig_sample,
    // Status
    output logic rec_ready,
    output logic rec_full,
    output logic [6:0] caps_stored,
    output logic [2:0] caps_pushed,
    // Events
    output fcr_pkg::fcr_event_t event_out
);
    typedef struct packed {
        logic [1:0] sr;
        logic keep;
        logic autox;
        logic [7:0] trg_en;
        logic fn60;
        logic [7:0] pre_ds;
        logic [15:0] len_ds;
        logic [7:0] an_sel;
        logic [94:0] dig_sel;
        fcr_pkg::fcr_st_t st;
        logic [17:0] dig_cnt;
        logic [31:0] rec_cnt;
        logic [31:0] ds_cnt;
        logic [6:0] caps;
        logic [6:0] newest_pushed;
        logic [2:0] pushed;
        logic full;
        logic trig_prev;
        logic [31:0] total_ds;
        logic [31:0] rdata;
        logic dig_stb;
        fcr_pkg::fcr_event_t ev;
        logic [31:0] free_bytes;
        logic ready;
        logic full_rep;
        logic [1:0] ev_pend;
    } fcr_state_t;
    fcr_state_t s_q, s_d;

    logic div_start, div_busy;
    logic [31:0] div_samples, div_rate, div_quot;
    logic trig_now;
    logic [31:0] an_rate;
    logic [31:0] post_ds;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] pop8(input logic [7:0] v);
        logic [7:0] n;
        n = 8'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {7'h0, v[i]};
        end
        return n;
    endfunction

    function automatic logic [7:0] pop95(input logic [94:0] v);
        logic [7:0] n;
        n = 8'h0;
        for (int i = 0; i < fcr_pkg::MAX_DIG_CH; i++) begin
            n = n + {7'h0, v[i]};
        end
        return n;
    endfunction

    function automatic logic [31:0] ds_cycles();
        return 32'(fcr_pkg::CLK_HZ / 10);
    endfunction

    // ------------------------------------------------------------
    // Capacity divider
    // ------------------------------------------------------------
    // Words per second: fn*(ch+1)*sr + 200*dig, divided by 10 to give deciseconds
    always_comb begin
        an_rate = (s_q.fn60 ? 32'h3C : 32'h32) * {24'h0, pop8(s_q.an_sel) + 8'h01}
                  * (32'h40 >> s_q.sr);
        div_rate = (an_rate + 32'hC8 * {24'h0, pop95(s_q.dig_sel)}) / 32'hA;
        div_samples = s_q.free_bytes / 32'(fcr_pkg::SAMPLE_BYTES);
    end
    assign div_start = reg_wr && reg_addr == fcr_pkg::REG_CMD
                       && reg_wdata[fcr_pkg::CMD_LOAD];

    fcr_len_calc u_len (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(div_start),
        .samples(div_samples),
        .rate(div_rate),
        .busy(div_busy),
        .quot(div_quot)
    );

    assign trig_now = |(trig_in & s_q.trg_en);
    assign post_ds = {16'h0, s_q.len_ds} - {24'h0, s_q.pre_ds};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ev.valid = 1'b0;
        s_d.ev.stamp = time_now;
        s_d.dig_stb = 1'b0;
        s_d.trig_prev = trig_now;
        if (!div_busy) begin
            s_d.total_ds = div_quot;
        end
        // Fixed digital sample tick, independent of the analog rate
        if (s_q.dig_cnt == 18'(fcr_pkg::DIG_PERIOD_CYC - 1)) begin
            s_d.dig_cnt = 18'h0;
            s_d.dig_stb = 1'b1;
        end else begin
            s_d.dig_cnt = s_q.dig_cnt + 18'h1;
        end
        // Recording sequencer; one event per cycle, clear commands win over state changes
        case (s_q.st)
            fcr_pkg::FCR_IDLE: begin
                if (trig_now && !s_q.trig_prev && s_q.total_ds != 32'h0) begin
                    if (s_q.full && s_q.keep) begin
                        s_d.st = fcr_pkg::FCR_IDLE;
                    end else begin
                        s_d.st = fcr_pkg::FCR_REC;
                        s_d.rec_cnt = post_ds;
                        s_d.ds_cnt = 32'h0;
                        s_d.ev.valid = 1'b1;
                        s_d.ev.code = fcr_pkg::FCR_EV_TRIG_ON;
                    end
                end
            end
            fcr_pkg::FCR_REC: begin
                if (s_q.ds_cnt == ds_cycles() - 32'h1) begin
                    s_d.ds_cnt = 32'h0;
                    s_d.rec_cnt = s_q.rec_cnt - 32'h1;
                end else begin
                    s_d.ds_cnt = s_q.ds_cnt + 32'h1;
                end
                if (s_q.rec_cnt == 32'h0) begin
                    s_d.st = fcr_pkg::FCR_STORE;
                    s_d.ev_pend = 2'h3;
                    s_d.ev.valid = 1'b1;
                    s_d.ev.code = fcr_pkg::FCR_EV_STO_ON;
                end else if (s_q.ds_cnt == 32'h0 && s_q.rec_cnt == post_ds) begin
                    s_d.ev.valid = 1'b1;
                    s_d.ev.code = fcr_pkg::FCR_EV_REC_ON;
                end
            end
            fcr_pkg::FCR_STORE: begin
                s_d.st = fcr_pkg::FCR_IDLE;
                s_d.ev.valid = 1'b1;
                s_d.ev.code = fcr_pkg::FCR_EV_STO_OFF;
                // Oldest dropped when full under overwrite policy
                if (s_q.caps != 7'(fcr_pkg::MAX_CAPS)) begin
                    s_d.caps = s_q.caps + 7'h1;
                end
                if (s_q.autox && s_q.pushed != 3'(fcr_pkg::MAX_PUSHED)) begin
                    s_d.pushed = s_q.pushed + 3'h1;
                    s_d.caps = s_q.caps;
                end
                s_d.full = (s_d.caps == 7'(fcr_pkg::MAX_CAPS));
            end
            default: s_d.st = fcr_pkg::FCR_IDLE;
        endcase
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                fcr_pkg::REG_CTRL: begin
                    s_d.sr = reg_wdata[fcr_pkg::CTRL_SR_LO +: 2];
                    s_d.keep = reg_wdata[fcr_pkg::CTRL_KEEP];
                    s_d.autox = reg_wdata[fcr_pkg::CTRL_AUTO];
                    s_d.trg_en = reg_wdata[fcr_pkg::CTRL_TRG_LO +: 8];
                    s_d.fn60 = reg_wdata[fcr_pkg::CTRL_FN60];
                end
                fcr_pkg::REG_PRE: begin
                    if (reg_wdata[7:0] >= 8'(fcr_pkg::PRE_MIN_DS)
                        && reg_wdata[7:0] <= 8'(fcr_pkg::PRE_MAX_DS)
                        && {8'h0, reg_wdata[7:0]} <= s_q.len_ds) begin
                        s_d.pre_ds = reg_wdata[7:0];
                    end
                end
                fcr_pkg::REG_LEN: s_d.len_ds = reg_wdata[15:0];
                fcr_pkg::REG_ANSEL: s_d.an_sel = reg_wdata[7:0];
                fcr_pkg::REG_DIG0: s_d.dig_sel[31:0] = reg_wdata;
                fcr_pkg::REG_DIG1: s_d.dig_sel[63:32] = reg_wdata;
                fcr_pkg::REG_DIG2: s_d.dig_sel[94:64] = reg_wdata[30:0];
                fcr_pkg::REG_FREE: s_d.free_bytes = reg_wdata;
                fcr_pkg::REG_CMD: begin
                    // Manual trigger is a self-clearing strobe; the capture it starts is stored, or pushed when auto-transfer has a free slot
                    if (reg_wdata[fcr_pkg::CMD_TRIG] && s_q.st == fcr_pkg::FCR_IDLE
                        && s_q.total_ds != 32'h0 && !(s_q.full && s_q.keep)) begin
                        s_d.st = fcr_pkg::FCR_REC;
                        s_d.rec_cnt = post_ds;
                        s_d.ds_cnt = 32'h0;
                        s_d.ev.valid = 1'b1;
                        s_d.ev.code = fcr_pkg::FCR_EV_TRIG_ON;
                    end
                    if (reg_wdata[fcr_pkg::CMD_POP] && s_q.pushed != 3'h0) begin
                        s_d.pushed = s_d.pushed - 3'h1;
                    end
                    if (reg_wdata[fcr_pkg::CMD_CLR_ALL]) begin
                        s_d.caps = 7'h0;
                        s_d.full = 1'b0;
                        s_d.ev.valid = 1'b1;
                        s_d.ev.code = fcr_pkg::FCR_EV_MEM_CLR;
                    end else if (reg_wdata[fcr_pkg::CMD_CLR_OLD] && s_q.caps != 7'h0) begin
                        s_d.caps = s_q.caps - 7'h1;
                        s_d.full = 1'b0;
                        s_d.ev.valid = 1'b1;
                        s_d.ev.code = fcr_pkg::FCR_EV_OLD_CLR;
                    end else if (reg_wdata[fcr_pkg::CMD_CLR_NEW] && s_q.caps != 7'h0) begin
                        s_d.caps = s_q.caps - 7'h1;
                        s_d.full = 1'b0;
                        s_d.ev.valid = 1'b1;
                        s_d.ev.code = fcr_pkg::FCR_EV_NEW_CLR;
                    end
                end
                default: ;
            endcase
        end
        // Full and end-of-capture events wait for a quiet cycle, so none is lost
        if (!s_d.ev.valid && s_d.full != s_q.full_rep) begin
            s_d.ev.valid = 1'b1;
            s_d.ev.code = s_d.full ? fcr_pkg::FCR_EV_FULL_ON : fcr_pkg::FCR_EV_FULL_OFF;
            s_d.full_rep = s_d.full;
        end else if (!s_d.ev.valid && s_q.ev_pend != 2'h0) begin
            s_d.ev.valid = 1'b1;
            s_d.ev.code = s_q.ev_pend[1] ? fcr_pkg::FCR_EV_REC_OFF : fcr_pkg::FCR_EV_TRIG_OFF;
            s_d.ev_pend = {1'b0, s_q.ev_pend[1]};
        end
        s_d.ready = (s_d.total_ds != 32'h0) && (|s_d.trg_en);
        // Read data, one cycle after the strobe; unmapped reads zero
        s_d.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                fcr_pkg::REG_CTRL: s_d.rdata = {15'h0, s_q.fn60, s_q.trg_en, 4'h0,
                                                s_q.autox, s_q.keep, s_q.sr};
                fcr_pkg::REG_PRE: s_d.rdata = {24'h0, s_q.pre_ds};
                fcr_pkg::REG_LEN: s_d.rdata = {16'h0, s_q.len_ds};
                fcr_pkg::REG_ANSEL: s_d.rdata = {24'h0, s_q.an_sel};
                fcr_pkg::REG_DIG0: s_d.rdata = s_q.dig_sel[31:0];
                fcr_pkg::REG_DIG1: s_d.rdata = s_q.dig_sel[63:32];
                fcr_pkg::REG_DIG2: s_d.rdata = {1'b0, s_q.dig_sel[94:64]};
                fcr_pkg::REG_STAT: s_d.rdata = {16'h0, 1'b0, s_q.caps, s_q.pushed,
                                                s_q.full, s_q.st, div_busy, s_q.ready};
                fcr_pkg::REG_TOTAL: s_d.rdata = s_q.total_ds;
                fcr_pkg::REG_FREE: s_d.rdata = s_q.free_bytes;
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.sr <= fcr_pkg::SR_RST;
            s_q.pre_ds <= fcr_pkg::PRE_RST_DS;
            s_q.len_ds <= fcr_pkg::LEN_RST_DS;
            s_q.free_bytes <= fcr_pkg::STORE_BYTES;
            s_q.st <= fcr_pkg::FCR_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign dig_sample = s_q.dig_stb;
    assign rec_ready = s_q.ready;
    assign rec_full = s_q.full;
    assign caps_stored = s_q.caps;
    assign caps_pushed = s_q.pushed;
    assign event_out = s_q.ev;
endmodule // fcr_ctrl
`default_nettype wire

//--- fcr_ctrl_properties.sv
// Concurrent checks on the fault capture recorder control ports
`timescale 1ns/100ps
`default_nettype none
module fcr_ctrl_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // Status and events
    input wire logic [31:0] time_now,
    input wire logic dig_sample,
    input wire logic rec_full,
    input wire logic [6:0] caps_stored,
    input wire logic [2:0] caps_pushed,
    input wire fcr_pkg::fcr_event_t event_out
);
    int dig_cnt_q;
    logic dig_seen_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Strobe gap is far too long to unroll, so it is counted here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dig_cnt_q <= 0;
            dig_seen_q <= 1'b0;
        end else begin
            dig_cnt_q <= dig_sample ? 0 : dig_cnt_q + 1;
            dig_seen_q <= dig_seen_q | dig_sample;
        end
    end
    sequence s_cmd(int b);
        reg_wr && reg_addr == fcr_pkg::REG_CMD && reg_wdata[b];
    endsequence
    chk_dig_period: assert property (dig_sample && dig_seen_q |->
        dig_cnt_q == fcr_pkg::DIG_PERIOD_CYC - 1) else $error("digital strobe spacing wrong");
    chk_dig_missing: assert property (dig_cnt_q <= fcr_pkg::DIG_PERIOD_CYC)
        else $error("digital strobe missing");
    chk_push_limit: assert property (caps_pushed <= 3'h6)
        else $error("too many pushed captures");
    chk_caps_limit: assert property (caps_stored <= 7'h64)
        else $error("too many stored captures");
    chk_full_level: assert property (rec_full == (caps_stored == 7'h64))
        else $error("full flag disagrees with count");
    chk_event_stamp: assert property (event_out.valid |->
        event_out.stamp == $past(time_now)) else $error("event stamp wrong");
    chk_clear_all: assert property (s_cmd(fcr_pkg::CMD_CLR_ALL) |=>
        caps_stored == 7'h00 && event_out.valid && event_out.code == fcr_pkg::FCR_EV_MEM_CLR)
        else $error("clear all not honoured");
    chk_pop_step: assert property (s_cmd(fcr_pkg::CMD_POP) ##0 caps_pushed != 3'h0 |=>
        caps_pushed == $past(caps_pushed) - 3'h1) else $error("retrieval did not free a slot");
    chk_caps_step: assert property ($changed(caps_stored) |-> caps_stored == 7'h00 ||
        caps_stored == $past(caps_stored) + 7'h01 || caps_stored == $past(caps_stored) - 7'h01)
        else $error("capture count jumped");
    chk_event_once: assert property (event_out.valid |=>
        !(event_out.valid && event_out.code == $past(event_out.code)))
        else $error("event repeated");
endmodule // fcr_ctrl_properties
bind fcr_ctrl fcr_ctrl_properties u_props (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .time_now(time_now), .dig_sample(dig_sample),
    .rec_full(rec_full), .caps_stored(caps_stored), .caps_pushed(caps_pushed),
    .event_out(event_out));
`default_nettype wire

//--- fcr_client_model.sv
// Retrieval client model that collects pushed captures
`timescale 1ns/100ps
`default_nettype none
module fcr_client_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Control
    input wire logic enable,
    input wire logic [7:0] delay,
    // Device status
    input wire logic [2:0] caps_pushed,
    // Request to the bench bus master
    output logic fetch_req
);
    logic [7:0] wait_q;
    // A slow client lets pushed captures pile up, which is the awkward case
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 8'h00;
        end else if (!enable || caps_pushed == 3'h0 || fetch_req) begin
            wait_q <= 8'h00;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end
    // Request fetch of one capture once the wait has run out; the bench does the removal
    assign fetch_req = enable && caps_pushed != 3'h0 && wait_q >= delay;
endmodule // fcr_client_model
`default_nettype wire

//--- disturbance_capture_control_tb.sv
// Self-checking testbench for the fault capture recorder control
`timescale 1ns/100ps
`default_nettype none
module disturbance_capture_control_tb;
    logic mclk, arst_n, reg_wr, reg_rd, dig_sample, rec_ready, rec_full, fetch_req, cl_en;
    logic [7:0] reg_addr, trig_in, cl_dly;
    logic [31:0] reg_wdata, reg_rdata, time_now, rd_v, an, d0, d1, d2;
    logic [6:0] caps_stored;
    logic [2:0] caps_pushed;
    fcr_pkg::fcr_event_t event_out;
    int n_errors, checked, seed, m_caps, m_push, m_auto, k, i, den, n_dig;
    int ev_cnt[16];
    int clr_bit[3] = '{fcr_pkg::CMD_CLR_NEW, fcr_pkg::CMD_CLR_OLD, fcr_pkg::CMD_CLR_ALL};
    fcr_pkg::fcr_ev_t clr_ev[3] = '{fcr_pkg::FCR_EV_NEW_CLR, fcr_pkg::FCR_EV_OLD_CLR,
        fcr_pkg::FCR_EV_MEM_CLR};
    fcr_ctrl dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
        .time_now(time_now), .dig_sample(dig_sample), .rec_ready(rec_ready),
        .rec_full(rec_full), .caps_stored(caps_stored), .caps_pushed(caps_pushed),
        .event_out(event_out));
    fcr_client_model u_client (.mclk(mclk), .arst_n(arst_n), .enable(cl_en), .delay(cl_dly),
        .caps_pushed(caps_pushed), .fetch_req(fetch_req));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        time_now <= time_now + 32'h1;
        if (event_out.valid === 1'b1) ev_cnt[event_out.code] += 1;
        if (dig_sample === 1'b1) n_dig++;
    end
    task automatic stop_test();
        $display("checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd_v = reg_rdata;
        chk(nm, e, rd_v);
    endtask
    task automatic wait_ev(input fcr_pkg::fcr_ev_t c, input int n0);
        for (int j = 0; j < 400 && ev_cnt[c] == n0; j++) @(posedge mclk);
        if (ev_cnt[c] == n0) begin
            n_errors++;
            $display("unexpected timeout on event %0d", c);
            stop_test();
        end
    endtask
    task automatic cap(input logic [7:0] src, input int acc);
        int n0, n1;
        n0 = ev_cnt[fcr_pkg::FCR_EV_TRIG_ON];
        n1 = ev_cnt[fcr_pkg::FCR_EV_STO_OFF];
        if (src == 8'h00) begin
            wr(fcr_pkg::REG_CMD, 32'h1);
        end else begin
            @(posedge mclk);
            trig_in <= src;
        end
        if (acc != 0) wait_ev(fcr_pkg::FCR_EV_STO_OFF, n1);
        repeat (20) @(posedge mclk);
        trig_in <= 8'h00;
        if (acc != 0 && m_auto != 0 && m_push < 6) m_push++;
        else if (acc != 0 && m_caps < 100) m_caps++;
        chk("trigger events", n0 + acc, ev_cnt[fcr_pkg::FCR_EV_TRIG_ON]);
        chk("trigger off events", n0 + acc, ev_cnt[fcr_pkg::FCR_EV_TRIG_OFF]);
        chk("recording off events", n0 + acc, ev_cnt[fcr_pkg::FCR_EV_REC_OFF]);
        chk("captures", m_caps, caps_stored);
        chk("pushed", m_push, caps_pushed);
    endtask
    task automatic clr(input int b, input fcr_pkg::fcr_ev_t c);
        int n0;
        n0 = ev_cnt[c];
        wr(fcr_pkg::REG_CMD, 32'h1 << b);
        repeat (2) @(posedge mclk);
        m_caps = (c == fcr_pkg::FCR_EV_MEM_CLR) ? 0 : m_caps - 1;
        chk("clear event", n0 + 1, ev_cnt[c]);
        chk("captures", m_caps, caps_stored);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 53;
        {arst_n, reg_wr, reg_rd, cl_en, reg_addr, trig_in, cl_dly, reg_wdata, time_now} = '0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rchk("ctrl", fcr_pkg::REG_CTRL, 32'h0);
        rchk("pre", fcr_pkg::REG_PRE, 32'(fcr_pkg::PRE_RST_DS));
        rchk("free", fcr_pkg::REG_FREE, fcr_pkg::STORE_BYTES);
        rchk("unmapped", 8'h30, 32'h0);
        chk("ready", 0, rec_ready);
        // Out of range and above the length must all be dropped
        wr(fcr_pkg::REG_PRE, 32'd1);
        wr(fcr_pkg::REG_PRE, 32'd151);
        wr(fcr_pkg::REG_PRE, 32'd11);
        rchk("pre", fcr_pkg::REG_PRE, 32'd2);
        wr(fcr_pkg::REG_PRE, 32'd10);
        rchk("pre", fcr_pkg::REG_PRE, 32'd10);
        wr(fcr_pkg::REG_PRE, 32'd2);
        for (k = 0; k < 4; k++) begin
            an = (k == 3) ? 32'hFF : $random(seed) & 32'hFF;
            d0 = (k == 3) ? '1 : $random(seed);
            d1 = (k == 3) ? '1 : $random(seed);
            d2 = ((k == 3) ? '1 : $random(seed)) & 32'h7FFF_FFFF;
            wr(fcr_pkg::REG_CTRL, 32'(k + ((k & 1) << 16)));
            wr(fcr_pkg::REG_ANSEL, an);
            wr(fcr_pkg::REG_DIG0, d0);
            wr(fcr_pkg::REG_DIG1, d1);
            wr(fcr_pkg::REG_DIG2, d2);
            wr(fcr_pkg::REG_CMD, 32'h1 << fcr_pkg::CMD_LOAD);
            repeat (34) @(posedge mclk);
            den = ((k & 1) ? 60 : 50) * ($countones(an) + 1) * (64 >> k)
                + 200 * ($countones(d0) + $countones(d1) + $countones(d2));
            rchk("total", fcr_pkg::REG_TOTAL, 32'(fcr_pkg::STORE_BYTES / 4 * 10 / den));
        end
        wr(fcr_pkg::REG_CTRL, 32'h100);
        wr(fcr_pkg::REG_LEN, 32'h2);
        wr(fcr_pkg::REG_CMD, 32'h1 << fcr_pkg::CMD_LOAD);
        repeat (34) @(posedge mclk);
        chk("ready", 1, rec_ready);
        cap(8'h00, 1);
        rchk("manual trigger", fcr_pkg::REG_CMD, 32'h0);
        cap(8'h01, 1);
        cap(8'h02, 0);
        m_auto = 1;
        wr(fcr_pkg::REG_CTRL, 32'h108);
        repeat (7) cap(8'h00, 1);
        cl_dly <= 8'($random(seed));
        cl_en <= 1'b1;
        repeat (6) begin
            for (i = 0; i < 300; i++) begin
                @(posedge mclk);
                if (fetch_req === 1'b1) break;
            end
            if (i == 300) chk("fetch request", 1, 0);
            wr(fcr_pkg::REG_CMD, 32'h1 << fcr_pkg::CMD_POP);
            @(posedge mclk);
            m_push--;
            chk("pushed", m_push, caps_pushed);
        end
        cl_en <= 1'b0;
        m_auto = 0;
        wr(fcr_pkg::REG_CTRL, 32'h100);
        for (k = 0; k < 3; k++) clr(clr_bit[k], clr_ev[k]);
        repeat (101) cap(8'h00, 1);
        chk("full", 1, rec_full);
        chk("full event", 1, ev_cnt[fcr_pkg::FCR_EV_FULL_ON]);
        wr(fcr_pkg::REG_CTRL, 32'h104);
        cap(8'h00, 0);
        clr(fcr_pkg::CMD_CLR_OLD, fcr_pkg::FCR_EV_OLD_CLR);
        wait_ev(fcr_pkg::FCR_EV_FULL_OFF, 0);
        chk("full", 0, rec_full);
        chk("digital strobes", (time_now - 32'h4) / 32'(fcr_pkg::DIG_PERIOD_CYC), n_dig);
        stop_test();
    end
endmodule // disturbance_capture_control_tb
`default_nettype wire
